/* File: sim/bcu_branch_condition_unit_tb_top.sv */
module bcu_branch_condition_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        i_clk;
    logic        i_sys_rst;
    logic        i_psel;
    logic        i_penable;
    logic        i_pwrite;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata;
    logic [31:0] o_prdata;
    logic        o_pready;
    logic        o_pslverr;
    logic [15:0] o_instruction_pointer;
    logic [15:0] o_code_segment;
    logic        o_branch_taken;
    int          mismatches;
    int          tests_run;
    int          taken_cnt;
    logic [31:0] rd;
    logic        err;
    logic [15:0] seg;
    logic [7:0]  dtab [4] = '{8'h7F, 8'h80, 8'h01, 8'hFF};

    initial i_clk = 1'b0;
    always #5 i_clk = ~i_clk;

    bcu_branch_unit dut_u (
        .i_clk                 (i_clk),
        .i_sys_rst             (i_sys_rst),
        .i_psel                (i_psel),
        .i_penable             (i_penable),
        .i_pwrite              (i_pwrite),
        .i_paddr               (i_paddr),
        .i_pwdata              (i_pwdata),
        .o_prdata              (o_prdata),
        .o_pready              (o_pready),
        .o_pslverr             (o_pslverr),
        .o_instruction_pointer (o_instruction_pointer),
        .o_code_segment        (o_code_segment),
        .o_branch_taken        (o_branch_taken)
    );

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one apb transfer; pready is waited for, the watchdog bounds the wait
    task automatic apb(input logic is_wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge i_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= is_wr;
        i_paddr   <= a;
        i_pwdata  <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do @(posedge i_clk); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        check("pslverr", {31'h0, err}, 32'h0000_0000);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, rd, exp);
    endtask

    task automatic jump(input logic [4:0] k, input logic [7:0] d,
                        input logic tk);
        apb(1'b1, bcu_pkg::OFS_CMD, {16'h0000, d, 3'h0, k});
        check("cmd_pslverr", {31'h0, err}, 32'h0000_0000);
        #1 check("taken_pulse", {31'h0, o_branch_taken}, {31'h0, tk});
        @(posedge i_clk);
        #1 check("pulse_end", {31'h0, o_branch_taken}, 32'h0000_0000);
        if (tk) taken_cnt++;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    initial begin
        repeat (50000) @(posedge i_clk);
        mismatches++;
        give_verdict();
    end

    initial begin
        logic [15:0] f;
        logic [15:0] cnt;
        logic [15:0] ptr;
        logic [15:0] eptr;
        logic [7:0]  d;
        logic        c;
        logic        z;
        logic        s;
        logic        o;
        logic        tk;
        i_sys_rst = 1'b1;
        i_psel    = 1'b0;
        i_penable = 1'b0;
        i_pwrite  = 1'b0;
        i_paddr   = 12'h000;
        i_pwdata  = 32'h0000_0000;
        mismatches = 0;
        tests_run = 0;
        taken_cnt = 0;
        repeat (16) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        rdchk("pointer_rst", bcu_pkg::OFS_IP, 32'h0000_0000);
        rdchk("flags_rst", bcu_pkg::OFS_FLAGS, 32'h0000_0000);
        rdchk("status_rst", bcu_pkg::OFS_STAT, 32'h0000_0000);
        seg = 16'h1234;
        wr(bcu_pkg::OFS_CS, {16'h0000, seg});
        // every conditional kind against all flag and count mixes
        for (int k = 0; k < 11; k++) begin
            for (int m = 0; m < 32; m++) begin
                {o, s, z, c} = 4'(m);
                cnt = m[4] ? 16'(m * 1025) : 16'h0000;
                f = 16'h0404;
                f[bcu_pkg::FLG_CARRY] = c;
                f[bcu_pkg::FLG_ZERO]  = z;
                f[bcu_pkg::FLG_SIGN]  = s;
                f[bcu_pkg::FLG_OVF]   = o;
                ptr = 16'hFFC0 + 16'(k * 3);
                d = dtab[m % 4];
                case (k)
                    0, 4:    tk = !c;
                    1, 3:    tk = c;
                    2:       tk = c | z;
                    5:       tk = (cnt == 16'h0000);
                    6:       tk = z;
                    7:       tk = (s == o) && !z;
                    8:       tk = (s == o);
                    9:       tk = (s != o);
                    default: tk = (s != o) || z;
                endcase
                eptr = tk ? ptr + {{8{d[7]}}, d} : ptr;
                wr(bcu_pkg::OFS_FLAGS, {16'h0000, f});
                wr(bcu_pkg::OFS_COUNT, {16'h0000, cnt});
                wr(bcu_pkg::OFS_IP, {16'h0000, ptr});
                jump(5'(k), d, tk);
                check("pointer", {16'h0, o_instruction_pointer},
                      {16'h0, eptr});
                check("segment", {16'h0, o_code_segment},
                      {16'h0, seg});
                rdchk("status", bcu_pkg::OFS_STAT,
                      {16'(taken_cnt), 15'h0, tk});
                rdchk("flags", bcu_pkg::OFS_FLAGS, {16'h0, f});
                rdchk("count", bcu_pkg::OFS_COUNT, {16'h0, cnt});
            end
        end
        // unconditional kinds, flags hold only the carry and the count is nonzero
        wr(bcu_pkg::OFS_FLAGS, 32'h0000_0001);
        wr(bcu_pkg::OFS_COUNT, 32'h0000_0007);
        wr(bcu_pkg::OFS_TGT, 32'h5A5A_0123);
        for (int k = 11; k < 17; k++) begin
            wr(bcu_pkg::OFS_IP, 32'h0000_0100);
            jump(5'(k), 8'hF0, 1'b1);
            if (k == 13 || k == 15) seg = 16'h5A5A;
            eptr = (k == 11) ? 16'h00F0 : 16'h0123;
            check("xfer_ptr", {16'h0, o_instruction_pointer},
                  {16'h0, eptr});
            check("xfer_seg", {16'h0, o_code_segment}, {16'h0, seg});
            rdchk("xfer_flags", bcu_pkg::OFS_FLAGS, 32'h0000_0001);
        end
        // invalid kinds change nothing but the status
        foreach (dtab[i]) begin
            wr(bcu_pkg::OFS_IP, 32'h0000_0200);
            jump(5'(17 + i * 4), 8'h10, 1'b0);
            check("bad_ptr", {16'h0, o_instruction_pointer}, 32'h0000_0200);
            rdchk("bad_status", bcu_pkg::OFS_STAT,
                  {16'(taken_cnt), 14'h0, 2'b10});
        end
        // unmapped place and read-only or write-only words
        apb(1'b1, 12'h01C, 32'hFFFF_FFFF);
        check("unmapped_wr_err", {31'h0, err}, 32'h0000_0001);
        apb(1'b0, 12'hFFC, 32'h0000_0000);
        check("unmapped_rd_err", {31'h0, err}, 32'h0000_0001);
        check("unmapped_rd", rd, 32'h0000_0000);
        wr(bcu_pkg::OFS_STAT, 32'hFFFF_FFFF);
        rdchk("status_ro", bcu_pkg::OFS_STAT, {16'(taken_cnt), 14'h0, 2'b10});
        rdchk("cmd_reads_zero", bcu_pkg::OFS_CMD, 32'h0000_0000);
        rdchk("pointer_kept", bcu_pkg::OFS_IP, 32'h0000_0200);
        // second reset in mid-run
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        @(posedge i_clk);
        #1 check("ptr_rst2", {16'h0, o_instruction_pointer}, 32'h0000_0000);
        check("seg_rst2", {16'h0, o_code_segment}, 32'h0000_0000);
        rdchk("target_rst2", bcu_pkg::OFS_TGT, 32'h0000_0000);
        rdchk("status_rst2", bcu_pkg::OFS_STAT, 32'h0000_0000);
        give_verdict();
    end
endmodule // bcu_branch_condition_unit_tb_top

/* File: verilog/bcu_branch_unit.sv */
module bcu_branch_unit (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // apb slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic [31:0]      o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // architectural view
    output logic [15:0]      o_instruction_pointer,
    output logic [15:0]      o_code_segment,
    output logic             o_branch_taken
);

    logic [15:0] ip_ff;
    logic [15:0] cs_ff;
    logic [15:0] count_ff;
    logic [15:0] flags_ff;
    logic [31:0] tgt_ff;
    logic        taken_ff;
    logic        bad_ff;
    logic [15:0] jcnt_ff;
    logic        pulse_ff;
    logic [31:0] prdata_ff;

    logic [15:0] nxt_ip;
    logic [15:0] nxt_cs;
    logic [15:0] nxt_count;
    logic [15:0] nxt_flags;
    logic [31:0] nxt_tgt;
    logic        nxt_taken;
    logic        nxt_bad;
    logic [15:0] nxt_jcnt;
    logic        nxt_pulse;
    logic [31:0] nxt_prdata;

    logic        access;
    logic        mapped;
    logic        wr_en;
    logic        exec;
    logic [4:0]  cmd_kind;
    logic [7:0]  short_displacement;
    logic        w_valid;
    logic        w_taken;
    logic [31:0] rd_val;

    assign access   = i_psel && i_penable;
    assign mapped   = (i_paddr == bcu_pkg::OFS_IP)
                   || (i_paddr == bcu_pkg::OFS_CS)
                   || (i_paddr == bcu_pkg::OFS_COUNT)
                   || (i_paddr == bcu_pkg::OFS_FLAGS)
                   || (i_paddr == bcu_pkg::OFS_CMD)
                   || (i_paddr == bcu_pkg::OFS_TGT)
                   || (i_paddr == bcu_pkg::OFS_STAT);
    assign wr_en    = access && i_pwrite && mapped;
    assign exec     = wr_en && (i_paddr == bcu_pkg::OFS_CMD);
    assign cmd_kind = i_pwdata[bcu_pkg::CMD_KIND_LSB +: bcu_pkg::CMD_KIND_W];
    assign short_displacement = i_pwdata[bcu_pkg::CMD_DISP_LSB +: 8];

    // zero wait states: every access completes in its first access cycle
    assign o_pready  = 1'b1;
    assign o_pslverr = access && !mapped;

    bcu_cond_eval u_cond (
        .i_kind  (cmd_kind),
        .i_flags (flags_ff),
        .i_count (count_ff),
        .o_valid (w_valid),
        .o_taken (w_taken)
    );

    always_comb begin
        case (i_paddr)
            bcu_pkg::OFS_IP:    rd_val = {16'h0000, ip_ff};
            bcu_pkg::OFS_CS:    rd_val = {16'h0000, cs_ff};
            bcu_pkg::OFS_COUNT: rd_val = {16'h0000, count_ff};
            bcu_pkg::OFS_FLAGS: rd_val = {16'h0000, flags_ff};
            bcu_pkg::OFS_TGT:   rd_val = tgt_ff;
            bcu_pkg::OFS_STAT: begin
                rd_val = 32'h0000_0000;
                rd_val[bcu_pkg::STAT_TAKEN]          = taken_ff;
                rd_val[bcu_pkg::STAT_BADKIND]        = bad_ff;
                rd_val[bcu_pkg::STAT_JCNT_LSB +: 16] = jcnt_ff;
            end
            default:            rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        nxt_ip     = ip_ff;
        nxt_cs     = cs_ff;
        nxt_count  = count_ff;
        nxt_flags  = flags_ff;
        nxt_tgt    = tgt_ff;
        nxt_taken  = taken_ff;
        nxt_bad    = bad_ff;
        nxt_jcnt   = jcnt_ff;
        nxt_pulse  = 1'b0;
        // read data is caught in the setup cycle so it leaves a flop
        nxt_prdata = prdata_ff;
        if (i_psel && !i_penable && !i_pwrite) begin
            nxt_prdata = rd_val;
        end
        if (wr_en) begin
            case (i_paddr)
                bcu_pkg::OFS_IP:    nxt_ip    = i_pwdata[15:0];
                bcu_pkg::OFS_CS:    nxt_cs    = i_pwdata[15:0];
                bcu_pkg::OFS_COUNT: nxt_count = i_pwdata[15:0];
                bcu_pkg::OFS_FLAGS: nxt_flags = i_pwdata[15:0];
                bcu_pkg::OFS_TGT:   nxt_tgt   = i_pwdata;
                bcu_pkg::OFS_CMD: begin
                    // flags, count and target stay put on every jump
                    nxt_bad   = !w_valid;
                    nxt_taken = w_valid && w_taken;
                    nxt_pulse = w_valid && w_taken;
                    if (w_valid && w_taken) begin
                        nxt_jcnt = jcnt_ff + 16'h0001;
                        case (bcu_pkg::bcu_kind_t'(cmd_kind))
                            bcu_pkg::xfer_far,
                            bcu_pkg::xfer_memptr_far: begin
                                nxt_ip = tgt_ff[bcu_pkg::TGT_OFS_LSB +: 16];
                                nxt_cs = tgt_ff[bcu_pkg::TGT_SEG_LSB +: 16];
                            end
                            bcu_pkg::xfer_near,
                            bcu_pkg::xfer_memptr_near,
                            bcu_pkg::xfer_regptr:
                                nxt_ip = tgt_ff[bcu_pkg::TGT_OFS_LSB +: 16];
                            default:
                                // 16-bit add drops the carry out, so the
                                // target wraps inside the same segment
                                nxt_ip = ip_ff + bcu_pkg::bcu_sext8(
                                    short_displacement);
                        endcase
                    end
                    // untaken: pointer already names the next instruction
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            ip_ff     <= bcu_pkg::RST_IP;
            cs_ff     <= bcu_pkg::RST_CS;
            count_ff  <= bcu_pkg::RST_COUNT;
            flags_ff  <= bcu_pkg::RST_FLAGS;
            tgt_ff    <= bcu_pkg::RST_TGT;
            taken_ff  <= 1'b0;
            bad_ff    <= 1'b0;
            jcnt_ff   <= 16'h0000;
            pulse_ff  <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ip_ff     <= nxt_ip;
            cs_ff     <= nxt_cs;
            count_ff  <= nxt_count;
            flags_ff  <= nxt_flags;
            tgt_ff    <= nxt_tgt;
            taken_ff  <= nxt_taken;
            bad_ff    <= nxt_bad;
            jcnt_ff   <= nxt_jcnt;
            pulse_ff  <= nxt_pulse;
            prdata_ff <= nxt_prdata;
        end
    end

    assign o_prdata              = prdata_ff;
    assign o_instruction_pointer = ip_ff;
    assign o_code_segment        = cs_ff;
    assign o_branch_taken        = pulse_ff;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    logic cf_h;
    logic zf_h;
    logic sf_h;
    logic of_h;
    assign cf_h = flags_ff[bcu_pkg::FLG_CARRY];
    assign zf_h = flags_ff[bcu_pkg::FLG_ZERO];
    assign sf_h = flags_ff[bcu_pkg::FLG_SIGN];
    assign of_h = flags_ff[bcu_pkg::FLG_OVF];

    // decisions are judged on the flags and count held at the command edge
    a_short_target_add: assert property (
        exec && w_taken && cmd_kind <= 5'h0B |=> ip_ff ==
        $past(ip_ff) + {{8{$past(i_pwdata[15])}}, $past(i_pwdata[15:8])})
        else $error("short branch target wrong");
    a_above_equal_cond: assert property (
        exec && cmd_kind == 5'h00 |=> o_branch_taken == !$past(cf_h))
        else $error("above-or-equal decision wrong");
    a_below_cond: assert property (
        exec && cmd_kind == 5'h01 |=> o_branch_taken == $past(cf_h))
        else $error("below decision wrong");
    a_carry_pair_cond: assert property (
        exec && (cmd_kind == 5'h03 || cmd_kind == 5'h04) |=>
        o_branch_taken == ($past(cf_h) ^ ($past(cmd_kind) == 5'h04)))
        else $error("carry branch decision wrong");
    a_below_equal_cond: assert property (
        exec && cmd_kind == 5'h02 |=>
        o_branch_taken == ($past(cf_h) || $past(zf_h)))
        else $error("below-or-equal decision wrong");
    a_count_zero_cond: assert property (
        exec && cmd_kind == 5'h05 |=>
        o_branch_taken == ($past(count_ff) == 16'h0000))
        else $error("count-zero decision wrong");
    a_equal_cond: assert property (
        exec && cmd_kind == 5'h06 |=> o_branch_taken == $past(zf_h))
        else $error("equal decision wrong");
    a_greater_cond: assert property (
        exec && cmd_kind == 5'h07 |=> o_branch_taken ==
        ($past(sf_h) == $past(of_h) && !$past(zf_h)))
        else $error("greater decision wrong");
    a_greater_eq_cond: assert property (
        exec && cmd_kind == 5'h08 |=>
        o_branch_taken == ($past(sf_h) == $past(of_h)))
        else $error("greater-or-equal decision wrong");
    a_less_cond: assert property (
        exec && cmd_kind == 5'h09 |=>
        o_branch_taken == ($past(sf_h) != $past(of_h)))
        else $error("less decision wrong");
    a_less_eq_cond: assert property (
        exec && cmd_kind == 5'h0A |=> o_branch_taken ==
        ($past(sf_h) != $past(of_h) || $past(zf_h)))
        else $error("less-or-equal decision wrong");
    a_far_loads_seg: assert property (
        exec && (cmd_kind == 5'h0D || cmd_kind == 5'h0F) |=>
        o_branch_taken && cs_ff == $past(tgt_ff[31:16])
        && ip_ff == $past(tgt_ff[15:0]))
        else $error("far transfer did not load segment");
    a_flags_untouched: assert property (
        exec |=> $stable(flags_ff) ##1 $stable(flags_ff) || wr_en)
        else $error("jump changed the flags");
    a_untaken_holds: assert property (
        exec && !w_taken |=> $stable(ip_ff) && $stable(cs_ff)
        && $stable(count_ff) && !o_branch_taken)
        else $error("untaken branch changed state");
    a_short_keeps_seg: assert property (
        exec && cmd_kind <= 5'h0B |=> $stable(cs_ff))
        else $error("short branch changed segment");

    // unconditional kinds: always taken, only far forms move the segment
    a_uncond_taken: assert property (
        exec && cmd_kind >= 5'h0B && cmd_kind <= 5'h10 |=> o_branch_taken)
        else $error("unconditional transfer not taken");
    a_short_uncond: assert property (
        exec && cmd_kind == 5'h0B |=> o_branch_taken && $stable(cs_ff))
        else $error("short unconditional transfer wrong");
    a_near_loads_ptr: assert property (
        exec && (cmd_kind == 5'h0C || cmd_kind == 5'h0E
        || cmd_kind == 5'h10) |=> ip_ff == $past(tgt_ff[15:0])
        && $stable(cs_ff))
        else $error("near transfer target wrong");

    // state that must hold: count on every jump, the rest when no valid taken jump or write moves it
    a_count_kept: assert property (
        exec |=> $stable(count_ff))
        else $error("jump changed the count register");
    a_flags_only_write: assert property (
        !(wr_en && i_paddr == bcu_pkg::OFS_FLAGS) |=> $stable(flags_ff))
        else $error("flags changed without a flags write");
    a_bad_kind_holds: assert property (
        exec && cmd_kind > 5'h10 |=> !o_branch_taken && $stable(ip_ff)
        && $stable(cs_ff) && $stable(count_ff))
        else $error("invalid kind changed state");
    a_untaken_status: assert property (
        exec && !w_taken |=> !taken_ff && jcnt_ff == $past(jcnt_ff))
        else $error("untaken branch counted as taken");
    a_no_spurious_pulse: assert property (
        !exec |=> !o_branch_taken)
        else $error("taken pulse without a command");
    a_ptr_held_idle: assert property (
        !exec && !(wr_en && i_paddr == bcu_pkg::OFS_IP)
        |=> $stable(ip_ff))
        else $error("pointer moved without a jump or write");

    // main scenarios: taken, untaken, far, wrap and invalid kind
    c_short_taken: cover property (exec && w_taken && cmd_kind == 5'h06);
    c_short_untaken: cover property (exec && !w_taken);
    c_far_xfer: cover property (exec && cmd_kind == 5'h0D);
    c_wrap_back: cover property (exec && w_taken && cmd_kind <= 5'h0B
        && i_pwdata[15] && ip_ff < 16'h0080);
    c_bad_kind: cover property (exec && !w_valid);

endmodule // bcu_branch_unit

/* File: verilog/bcu_cond_eval.sv */
module bcu_cond_eval (
    // decoded jump kind
    input  wire logic [4:0]  i_kind,
    // architectural state
    input  wire logic [15:0] i_flags,
    input  wire logic [15:0] i_count,
    // verdict
    output logic             o_valid,
    output logic             o_taken
);

    logic carry_flag;
    logic zero_result_flag;
    logic sign_flag;
    logic overflow_flag;

    assign carry_flag       = i_flags[bcu_pkg::FLG_CARRY];
    assign zero_result_flag = i_flags[bcu_pkg::FLG_ZERO];
    assign sign_flag        = i_flags[bcu_pkg::FLG_SIGN];
    assign overflow_flag    = i_flags[bcu_pkg::FLG_OVF];

    always_comb begin
        o_valid = (i_kind <= bcu_pkg::KIND_LAST);
        o_taken = 1'b0;
        case (bcu_pkg::bcu_kind_t'(i_kind))
            bcu_pkg::branch_above_or_equal:
                o_taken = !carry_flag;
            bcu_pkg::branch_below:
                o_taken = carry_flag;
            bcu_pkg::branch_on_carry:
                o_taken = carry_flag;
            bcu_pkg::branch_on_no_carry:
                o_taken = !carry_flag;
            bcu_pkg::branch_below_or_equal:
                o_taken = carry_flag || zero_result_flag;
            bcu_pkg::branch_count_zero:
                o_taken = (i_count == 16'h0000);
            bcu_pkg::branch_equal:
                o_taken = zero_result_flag;
            bcu_pkg::branch_signed_greater:
                o_taken = (sign_flag == overflow_flag)
                          && !zero_result_flag;
            bcu_pkg::branch_signed_greater_equal:
                o_taken = (sign_flag == overflow_flag);
            bcu_pkg::branch_signed_less:
                o_taken = (sign_flag != overflow_flag);
            bcu_pkg::branch_signed_less_equal:
                o_taken = (sign_flag != overflow_flag)
                          || zero_result_flag;
            bcu_pkg::xfer_short, bcu_pkg::xfer_near,
            bcu_pkg::xfer_far, bcu_pkg::xfer_memptr_near,
            bcu_pkg::xfer_memptr_far, bcu_pkg::xfer_regptr:
                o_taken = 1'b1;
            default:
                o_taken = 1'b0;
        endcase
    end

endmodule // bcu_cond_eval

/* File: verilog/bcu_pkg.sv */
package bcu_pkg;

    // register byte offsets on the apb window
    localparam logic [11:0] OFS_IP    = 12'h000;
    localparam logic [11:0] OFS_CS    = 12'h004;
    localparam logic [11:0] OFS_COUNT = 12'h008;
    localparam logic [11:0] OFS_FLAGS = 12'h00C;
    localparam logic [11:0] OFS_CMD   = 12'h010;
    localparam logic [11:0] OFS_TGT   = 12'h014;
    localparam logic [11:0] OFS_STAT  = 12'h018;

    // status flag positions inside the flags word
    localparam int unsigned FLG_CARRY = 0;
    localparam int unsigned FLG_ZERO  = 6;
    localparam int unsigned FLG_SIGN  = 7;
    localparam int unsigned FLG_OVF   = 11;

    // command word fields
    localparam int unsigned CMD_KIND_LSB = 0;
    localparam int unsigned CMD_KIND_W   = 5;
    localparam int unsigned CMD_DISP_LSB = 8;

    // target word fields
    localparam int unsigned TGT_OFS_LSB = 0;
    localparam int unsigned TGT_SEG_LSB = 16;

    // status word fields
    localparam int unsigned STAT_TAKEN   = 0;
    localparam int unsigned STAT_BADKIND = 1;
    localparam int unsigned STAT_JCNT_LSB = 16;

    // reset values
    localparam logic [15:0] RST_IP    = 16'h0000;
    localparam logic [15:0] RST_CS    = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [31:0] RST_TGT   = 32'h0000_0000;

    typedef enum logic [4:0] {
        branch_above_or_equal,
        branch_below,
        branch_below_or_equal,
        branch_on_carry,
        branch_on_no_carry,
        branch_count_zero,
        branch_equal,
        branch_signed_greater,
        branch_signed_greater_equal,
        branch_signed_less,
        branch_signed_less_equal,
        xfer_short,
        xfer_near,
        xfer_far,
        xfer_memptr_near,
        xfer_memptr_far,
        xfer_regptr
    } bcu_kind_t;

    localparam logic [4:0] KIND_LAST = 5'h10;

    function automatic logic [15:0] bcu_sext8(input logic [7:0] d);
        bcu_sext8 = {{8{d[7]}}, d};
    endfunction

endpackage
